/* pmcc_config.sv */
// Purpose: Configuration register and front-end decode of the monitor
// Assumes: Serial engine delivers decoded register writes and call codes
// Notes:   Analog path is outside; this block only steers it
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Enable field zero disables measurement path
// - Enable field one returns to active
// - Result valid 40 us after wake
// - General-call enable/disable also toggle state
// - Call codes 81h enable, 82h disable, 06h reset
// - Bits D5:D4 select output source
// - Bits D3:D2 select shunt gain
// - Bits D1:D0 select bus attenuation
// - Power-on value 0x0061
// - Supply power takes bus from supply side
// - Load power takes bus from load side
// - Bus voltage mode always uses supply side
// - Power gain follows gain and attenuation pair
module pmcc_config #(
  parameter int WAKE_CYC = pmcc_pkg::WAKE_CYC
) (
  input  wire logic                      clock,
  input  wire logic                      rst_b,
  input  wire pmcc_pkg::pmcc_wr_t        cfg_wr,
  input  wire pmcc_pkg::pmcc_gc_t        gen_call,
  output var  logic [15:0]               monitor_configuration,
  output var  pmcc_pkg::pmcc_front_end_t front_end,
  output logic                           bus_from_load_side,
  output logic [15:0]                    power_gain_milli,
  output logic                           result_valid
);

  //////////////////////////////////////////////////////////////////////////////
  // Decode helpers
  function automatic logic [1:0] fix_code(input logic [1:0] code,
                                          input logic [1:0] dflt);
    fix_code = (code == 2'h3) ? dflt : code;
  endfunction : fix_code

  localparam logic [1:0] GAIN_DFLT = pmcc_pkg::CFG_RESET[3:2];
  localparam logic [1:0] ATT_DFLT  = pmcc_pkg::CFG_RESET[1:0];

  //////////////////////////////////////////////////////////////////////////////
  // Register and call handling
  logic [15:0] cfg;
  logic [15:0] next_cfg;

  wire gc_en  = gen_call.gc_strobe && gen_call.gc_code == pmcc_pkg::GC_ENABLE;
  wire gc_dis = gen_call.gc_strobe && gen_call.gc_code == pmcc_pkg::GC_DISABLE;
  wire gc_rst = gen_call.gc_strobe && gen_call.gc_code == pmcc_pkg::GC_RESET;

  // A call arriving with a register write wins for the enable bit,
  // since it is the later, bus-wide intent
  always_comb begin
    next_cfg = cfg;
    if (gc_rst) begin
      next_cfg = pmcc_pkg::CFG_RESET;
    end else begin
      if (cfg_wr.wr_strobe) begin
        next_cfg = cfg_wr.wr_data & pmcc_pkg::CFG_WRITE_MASK;
      end
      if (gc_en) begin
        next_cfg[pmcc_pkg::EN_BIT] = 1'b1;
      end else if (gc_dis) begin
        next_cfg[pmcc_pkg::EN_BIT] = 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cfg <= pmcc_pkg::CFG_RESET;
    end else begin
      cfg <= next_cfg;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Front-end decode
  wire [1:0] src_raw  = cfg[pmcc_pkg::SRC_LSB +: 2];
  wire [1:0] gain_eff = fix_code(cfg[pmcc_pkg::GAIN_LSB +: 2], GAIN_DFLT);
  wire [1:0] att_eff  = fix_code(cfg[pmcc_pkg::ATTEN_LSB +: 2], ATT_DFLT);

  assign monitor_configuration = cfg;
  // Measurement path off while disabled; one driver for the whole struct
  assign front_end = '{
    enable: cfg[pmcc_pkg::EN_BIT],
    source: pmcc_pkg::pmcc_src_t'(src_raw),
    gain:   pmcc_pkg::pmcc_gain_t'(gain_eff),
    atten:  pmcc_pkg::pmcc_att_t'(att_eff)
  };

  // Only load power moves the bus tap; bus and supply modes use supply side
  assign bus_from_load_side =
    (src_raw == pmcc_pkg::PMCC_SRC_LOAD);

  //////////////////////////////////////////////////////////////////////////////
  // Power gain table, value times 1000
  always_comb begin
    case ({att_eff, gain_eff})
      4'h0:    power_gain_milli = 16'h0a6b; // 2/5, 20  -> 2.667
      4'h1:    power_gain_milli = 16'h42ab; // 2/5, 128 -> 17.067
      4'h2:    power_gain_milli = 16'h9c40; // 2/5, 300 -> 40
      4'h4:    power_gain_milli = 16'h0535; // 1/5, 20  -> 1.333
      4'h5:    power_gain_milli = 16'h2155; // 1/5, 128 -> 8.533
      4'h6:    power_gain_milli = 16'h4e20; // 1/5, 300 -> 20
      4'h8:    power_gain_milli = 16'h029b; // 1/10, 20  -> 0.667
      4'h9:    power_gain_milli = 16'h10ab; // 1/10, 128 -> 4.267
      4'ha:    power_gain_milli = 16'h2710; // 1/10, 300 -> 10
      default: power_gain_milli = 16'h0535;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Wake-up validity
  pmcc_wake_timer #(
    .WAKE_CYC (WAKE_CYC)
  ) u_wake (
    .clock        (clock),
    .rst_b        (rst_b),
    .enable       (cfg[pmcc_pkg::EN_BIT]),
    .result_valid (result_valid)
  );

endmodule : pmcc_config
`default_nettype wire

/* pmcc_pkg.sv */
// Purpose: Shared constants and types for the monitor configuration block
// Assumes: 25 MHz clock; register access through the serial bus engine
// Notes:   Field positions, reset value and wake-up timing live here
package pmcc_pkg;

  localparam int          REG_W          = 16;
  localparam logic [15:0] CFG_RESET      = 16'h0061;
  localparam logic [15:0] CFG_WRITE_MASK = 16'h007f;
  localparam int          EN_BIT         = 6;
  localparam int          SRC_LSB        = 4;
  localparam int          GAIN_LSB       = 2;
  localparam int          ATTEN_LSB      = 0;

  localparam logic [7:0]  GC_RESET       = 8'h06;
  localparam logic [7:0]  GC_ENABLE      = 8'h81;
  localparam logic [7:0]  GC_DISABLE     = 8'h82;

  localparam int          CLK_HZ         = 25000000;
  localparam int          WAKE_US        = 40;
  localparam int          WAKE_CYC       = (WAKE_US * (CLK_HZ / 1000000) < 1)
                                         ? 1 : WAKE_US * (CLK_HZ / 1000000);

  typedef enum logic [1:0] {
    PMCC_SRC_BUS    = 2'h0,
    PMCC_SRC_SHUNT  = 2'h1,
    PMCC_SRC_SUPPLY = 2'h2,
    PMCC_SRC_LOAD   = 2'h3
  } pmcc_src_t;

  typedef enum logic [1:0] {
    PMCC_GAIN_20  = 2'h0,
    PMCC_GAIN_128 = 2'h1,
    PMCC_GAIN_300 = 2'h2
  } pmcc_gain_t;

  typedef enum logic [1:0] {
    PMCC_ATT_2_5  = 2'h0,
    PMCC_ATT_1_5  = 2'h1,
    PMCC_ATT_1_10 = 2'h2
  } pmcc_att_t;

  // Power gain times 1000, rounded as printed
  localparam int          PGAIN_W        = 16;

  typedef struct packed {
    logic       enable;
    pmcc_src_t  source;
    pmcc_gain_t gain;
    pmcc_att_t  atten;
  } pmcc_front_end_t;

  typedef struct packed {
    logic        wr_strobe;
    logic [15:0] wr_data;
  } pmcc_wr_t;

  typedef struct packed {
    logic       gc_strobe;
    logic [7:0] gc_code;
  } pmcc_gc_t;

endpackage : pmcc_pkg

/* pmcc_wake_timer.sv */
// Purpose: Wake-up interval counter after leaving the disabled state
// Assumes: enable is a registered level in the clock domain
// Notes:   Valid drops on the first edge after disable; restarts on every wake
`timescale 1ns/100ps
`default_nettype none
module pmcc_wake_timer #(
  parameter int WAKE_CYC = pmcc_pkg::WAKE_CYC
) (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic enable,
  output var  logic result_valid
);

  localparam int CW = $clog2(WAKE_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(WAKE_CYC);

  logic [CW-1:0] count;
  logic          enable_q;
  wire           done   = (count == LAST);
  wire           waking = enable & ~enable_q;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count        <= '0;
      enable_q     <= 1'b0;
      result_valid <= 1'b0;
    end else begin
      enable_q <= enable;
      if (!enable || waking) begin
        count        <= '0;
        result_valid <= 1'b0;
      end else if (!done) begin
        count <= count + CW'(1);
      end else begin
        result_valid <= 1'b1;
      end
    end
  end

endmodule : pmcc_wake_timer
`default_nettype wire

/* pmcc_config_props.sv */
// Purpose: Port checks of the monitor configuration block
// Assumes: Wake count of 8 in simulation
// Notes:   Bound to every pmcc_config
`timescale 1ns/100ps
`default_nettype none
module pmcc_config_props #(parameter int WAKE_CYC = 8) (
  input wire logic                      clock,
  input wire logic                      rst_b,
  input wire pmcc_pkg::pmcc_wr_t        cfg_wr,
  input wire pmcc_pkg::pmcc_gc_t        gen_call,
  input wire logic [15:0]               monitor_configuration,
  input wire pmcc_pkg::pmcc_front_end_t front_end,
  input wire logic                      bus_from_load_side,
  input wire logic [15:0]               power_gain_milli,
  input wire logic                      result_valid
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  wire        gc = gen_call.gc_strobe;
  wire [7:0]  cd = gen_call.gc_code;
  wire [15:0] cf = monitor_configuration;
  // One edge restarts the count and one more raises the flag
  localparam int WAKE_AT = WAKE_CYC + 2;
  a_reserved_zero: assert property (cf[15:7] == 9'h000)
    else $error("reserved bits set");
  a_write_stored: assert property (cfg_wr.wr_strobe && !gc |=>
    cf == ($past(cfg_wr.wr_data) & 16'h007f)) else $error("bad write");
  a_call_enable: assert property (
    gc && cd == 8'h81 |=> front_end.enable) else $error("call enable lost");
  a_call_disable: assert property (
    gc && cd == 8'h82 |=> !front_end.enable) else $error("call off lost");
  a_call_reset: assert property (gc && cd == 8'h06 |=> cf == 16'h0061)
    else $error("call reset lost");
  a_source_decode: assert property (front_end.source == cf[5:4])
    else $error("bad source");
  a_gain_decode: assert property (front_end.gain ==
    ((cf[3:2] == 2'h3) ? 2'h0 : cf[3:2])) else $error("bad gain");
  a_atten_decode: assert property (front_end.atten ==
    ((cf[1:0] == 2'h3) ? 2'h1 : cf[1:0])) else $error("bad atten");
  a_load_side: assert property (
    bus_from_load_side == (cf[5:4] == 2'h3)) else $error("bad bus side");
  a_valid_off: assert property (!front_end.enable |=> !result_valid)
    else $error("valid while off");
  // Valid stays low through the count and rises exactly at its end
  a_wake_wait: assert property ($rose(front_end.enable) |->
    !result_valid [*8] and ##[WAKE_AT:WAKE_AT] $rose(result_valid))
    else $error("bad wake");
  c_wake: cover property ($rose(result_valid));
  c_load: cover property (bus_from_load_side);
  c_reset: cover property (gc && cd == 8'h06);
endmodule : pmcc_config_props
bind pmcc_config pmcc_config_props #(.WAKE_CYC(WAKE_CYC)) props_u (
  .clock(clock), .rst_b(rst_b), .cfg_wr(cfg_wr), .gen_call(gen_call),
  .monitor_configuration(monitor_configuration), .front_end(front_end),
  .bus_from_load_side(bus_from_load_side),
  .power_gain_milli(power_gain_milli), .result_valid(result_valid));
`default_nettype wire

/* pmcc_host_model.sv */
// Purpose: Bus host that sends register writes and call codes
// Assumes: Engine hands over whole words as one-cycle pulses
// Notes:   Released data is inverted so stale values never pass
`timescale 1ns/100ps
`default_nettype none
module pmcc_host_model (
  input  wire logic               clock,
  output var  pmcc_pkg::pmcc_wr_t cfg_wr,
  output var  pmcc_pkg::pmcc_gc_t gen_call
);
  initial begin
    cfg_wr = '0;
    gen_call = '0;
  end
  task automatic wr(input logic [15:0] d);
    @(negedge clock);
    cfg_wr = '{1'b1, d};
    @(negedge clock);
    cfg_wr = '{1'b0, ~d};
  endtask : wr
  task automatic call(input logic [7:0] c);
    @(negedge clock);
    gen_call = '{1'b1, c};
    @(negedge clock);
    gen_call = '{1'b0, ~c};
  endtask : call
endmodule : pmcc_host_model
`default_nettype wire

/* testbench.sv */
// Purpose: Self-checking bench of the monitor configuration block
// Assumes: Wake count shortened to 8
// Notes:   Register is read straight from its port
`timescale 1ns/100ps
`default_nettype none
module testbench;
  // Short wake count keeps the run brief; the design default is 40 us
  localparam int          WAKE_SIM   = 8;
  localparam logic [7:0]  GC_SEQ [4] = '{8'h82, 8'h55, 8'h81, 8'h06};
  localparam logic [15:0] GC_EXP [4] = '{16'h0000, 16'h0000, 16'h0040,
                                         16'h0061};
  logic                      clock;
  logic                      rst_b;
  pmcc_pkg::pmcc_wr_t        cfg_wr;
  pmcc_pkg::pmcc_gc_t        gen_call;
  logic [15:0]               cfg;
  pmcc_pkg::pmcc_front_end_t fe;
  logic                      lside;
  logic [15:0]               pg;
  logic                      valid;
  int                        mismatches;
  int                        checked;
  logic [15:0] ptab [3][3] = '{'{16'h0a6b, 16'h0535, 16'h029b},
    '{16'h42ab, 16'h2155, 16'h10ab}, '{16'h9c40, 16'h4e20, 16'h2710}};
  pmcc_config #(.WAKE_CYC(WAKE_SIM)) dut_u (.clock(clock), .rst_b(rst_b),
    .cfg_wr(cfg_wr), .gen_call(gen_call), .monitor_configuration(cfg),
    .front_end(fe), .bus_from_load_side(lside), .power_gain_milli(pg),
    .result_valid(valid));
  pmcc_host_model host_u (.clock(clock), .cfg_wr(cfg_wr),
    .gen_call(gen_call));
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task wake;
    for (int n = 0; n < 30 && valid !== 1'b1; n++) @(negedge clock);
    chk({15'h0, valid}, 16'h0001);
  endtask : wake
  task results;
    if (mismatches == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    #200000;
    mismatches++;
    results();
  end
  initial begin
    logic [5:0] w;
    logic [1:0] g;
    logic [1:0] a;
    rst_b = 1'b0;
    repeat (12) @(negedge clock);
    rst_b = 1'b1;
    chk(cfg, 16'h0061);
    chk({9'h0, fe}, 16'h0061);
    wake();
    host_u.wr(16'hffff);
    chk(cfg, 16'h007f);
    chk({9'h0, fe}, 16'h0071);
    for (int i = 0; i < 64; i++) begin
      w = i[5:0];
      g = (w[3:2] == 2'h3) ? 2'h0 : w[3:2];
      a = (w[1:0] == 2'h3) ? 2'h1 : w[1:0];
      host_u.wr({9'h0, 1'b1, w});
      chk(cfg, {9'h0, 1'b1, w});
      chk(fe.source, w[5:4]);
      chk(lside, w[5:4] == 2'h3);
      chk(pg, ptab[g][a]);
      chk({fe.gain, fe.atten}, {g, a});
    end
    host_u.wr(16'h0000);
    chk(fe.enable, 1'b0);
    @(negedge clock);
    chk(valid, 1'b0);
    host_u.wr(16'h0040);
    chk(fe.enable, 1'b1);
    wake();
    for (int k = 0; k < 4; k++) begin
      host_u.call(GC_SEQ[k]);
      chk(cfg, GC_EXP[k]);
    end
    // Same-cycle write and call: the call has the last word on enable
    fork
      host_u.wr(16'h0000);
      host_u.call(8'h81);
    join
    chk(cfg, 16'h0040);
    fork
      host_u.wr(16'h0070);
      host_u.call(8'h06);
    join
    chk(cfg, 16'h0061);
    // Reset in mid-run while disabled must restore the power-on word
    host_u.wr(16'h0000);
    rst_b = 1'b0;
    repeat (2) @(negedge clock);
    chk(cfg, 16'h0061);
    chk(valid, 1'b0);
    rst_b = 1'b1;
    wake();
    results();
  end
endmodule : testbench
`default_nettype wire
